// file: include/ixd_pkg.sv
// package of constants and types for the integer execution datapath
package ixd_pkg;
	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_OPA    = 12'h004;
	localparam logic [11:0] ADDR_OPB    = 12'h008;
	localparam logic [11:0] ADDR_OPC    = 12'h00c;
	localparam logic [11:0] ADDR_RES    = 12'h010;
	localparam logic [11:0] ADDR_RESHI  = 12'h014;
	localparam logic [11:0] ADDR_FLAGS  = 12'h018;
	localparam logic [11:0] ADDR_QUOT   = 12'h01c;
	localparam logic [11:0] ADDR_REM    = 12'h020;
	localparam logic [11:0] ADDR_IRQST  = 12'h024;
	localparam logic [11:0] ADDR_IRQMSK = 12'h028;
	localparam logic [11:0] ADDR_BUSY   = 12'h02c;

	// ****************************************************************
	// control word fields
	// ****************************************************************
	localparam int CTRL_OP_LSB  = 0;
	localparam int CTRL_BYTE    = 5;
	localparam int CTRL_SRC_MEM = 6;
	localparam int CTRL_DST_MEM = 7;
	localparam int CTRL_GO      = 8;

	// flags register bit positions
	localparam int FL_C  = 0;
	localparam int FL_Z  = 1;
	localparam int FL_OV = 2;
	localparam int FL_N  = 3;
	localparam int FL_DC = 8;

	// interrupt status bit positions
	localparam int IRQ_DONE = 0;
	localparam int IRQ_DIV0 = 1;

	localparam logic [15:0] FLAGS_RST = 16'h0000;
	localparam logic [1:0]  IRQ_RST   = 2'h0;
	localparam logic [4:0]  DIV_STEPS = 5'h10;

	typedef enum logic [4:0] {
		IXD_ADD, IXD_SUB, IXD_AND, IXD_IOR, IXD_XOR,
		IXD_SHIFT_A, IXD_SHIFT_L,
		IXD_MUL_SS, IXD_MUL_UU, IXD_MUL_US,
		IXD_MUL_SL5, IXD_MUL_UL5, IXD_MUL_BB,
		IXD_DIV_S32, IXD_DIV_U32, IXD_DIV_S16, IXD_DIV_U16
	} ixd_op_t;
endpackage : ixd_pkg

// file: hdl/ixd_shift.sv
// single-cycle signed-amount barrel shifter
`timescale 1ns/1ps
module ixd_shift (
	input  wire logic [15:0] i_val,
	input  wire logic [4:0]  i_amt,
	input  wire logic        i_arith,
	output logic      [15:0] o_val
);
	logic [4:0]  mag;
	logic [31:0] ext;

	always_comb begin
		mag = i_amt[4] ? 5'(-i_amt) : i_amt;
		ext = {{16{i_arith & i_val[15]}}, i_val};
		// positive right, negative left, zero untouched
		if (i_amt == 5'h00) begin
			o_val = i_val;
		end else if (i_amt[4]) begin
			o_val = 16'(i_val << mag);
		end else begin
			o_val = 16'(ext >> mag);
		end
	end
endmodule : ixd_shift

// file: hdl/ixd_top.sv
// integer execution datapath: alu, multiplier, divider, shifter
`timescale 1ns/1ps
// Overview of operation
// - 16-bit add, subtract, shift, logic operations
// - arithmetic is two's complement by default
// - carry, zero, sign, overflow, nibble flags update
// - subtract carries are inverted borrows
// - byte or word width per instruction
// - first operand from register or memory; non-divide results also to memory
// - 17x17 multiplier with sign/zero extension
// - six multiply modes incl literal and byte
// - signed/unsigned 32/16 and 16/16 divide
// - quotient to quotient reg, remainder to remainder
// - any nonzero divisor; aligned pair gives 32-bit dividend
// - one cycle per divisor bit, equal length
// - single-cycle shift up to 16 bits
// - shift source register or memory
// - signed amount: positive right, negative left
// - zero divisor raises trap and sets flag
module ixd_top (
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [11:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	input  wire logic [15:0] I_MEM_DATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	output logic             O_BUSY,
	output logic             O_IRQ,
	output logic             O_MATH_TRAP,
	output logic             O_MEM_WE,
	output logic      [15:0] O_MEM_WDATA
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_FIX} ixd_st_t;

	typedef struct packed {
		ixd_st_t     st;
		logic [8:0]  ctrl;
		logic [15:0] opa;
		logic [15:0] opb;
		logic [15:0] opc;
		logic [15:0] res;
		logic [15:0] reshi;
		logic [15:0] flags;
		logic [15:0] quot;
		logic [15:0] rem;
		logic [1:0]  irq_st;
		logic [1:0]  irq_msk;
		logic [31:0] dq;
		logic [16:0] acc;
		logic [15:0] dsr;
		logic [4:0]  cnt;
		logic        neg_q;
		logic        neg_r;
		logic [31:0] prdata;
		logic        pready;
		logic        slverr;
		logic        busy;
		logic        irq;
		logic        trap;
		logic        mem_we;
		logic [15:0] mem_wdata;
	} ixd_state_t;

	ixd_state_t s_r;
	ixd_state_t s_nxt;

	logic [15:0] shift_out;
	logic [15:0] src;
	logic        setup;
	logic        acc_wr;
	logic        acc_rd;
	ixd_pkg::ixd_op_t op;

	assign op  = ixd_pkg::ixd_op_t'(s_r.ctrl[4:0]);
	assign src = s_r.ctrl[ixd_pkg::CTRL_SRC_MEM] ? I_MEM_DATA : s_r.opa;
	assign setup  = I_PSEL & ~I_PENABLE;
	assign acc_wr = I_PSEL & I_PENABLE & I_PWRITE & s_r.pready;
	assign acc_rd = I_PSEL & ~I_PWRITE & setup;

	ixd_shift u_shift (
		.i_val   (src),
		.i_amt   (s_r.opb[4:0]),
		.i_arith (op == ixd_pkg::IXD_SHIFT_A),
		.o_val   (shift_out)
	);

	// ****************************************************************
	// datapath and bus
	// ****************************************************************
	always_comb begin
		logic [16:0] ma;
		logic [16:0] mb;
		logic [33:0] prod;
		logic [16:0] sum;
		logic [4:0]  nib;
		logic [15:0] r;
		logic        byt;
		logic        co;
		logic        dco;
		logic        ovf;
		logic        msb;
		logic [15:0] b_eff;
		logic [31:0] dvd;
		logic [15:0] dvs;
		logic        sgn;
		logic        long;
		logic [16:0] trial;
		logic [1:0]  ev;
		logic [7:0]  r8;
		ma = 17'h00000;
		mb = 17'h00000;
		prod = 34'h000000000;
		sum = 17'h00000;
		nib = 5'h00;
		r = 16'h0000;
		byt = 1'b0;
		co = 1'b0;
		dco = 1'b0;
		ovf = 1'b0;
		msb = 1'b0;
		b_eff = 16'h0000;
		dvd = 32'h00000000;
		dvs = 16'h0000;
		sgn = 1'b0;
		long = 1'b0;
		trial = 17'h00000;
		ev = 2'h0;
		r8 = 8'h00;
		s_nxt = s_r;
		s_nxt.mem_we = 1'b0;
		s_nxt.pready = setup;
		s_nxt.slverr = 1'b0;

		// register writes take effect in the access phase
		if (acc_wr) begin
			case (I_PADDR)
			ixd_pkg::ADDR_CTRL:   s_nxt.ctrl = I_PWDATA[8:0];
			ixd_pkg::ADDR_OPA:    s_nxt.opa = I_PWDATA[15:0];
			ixd_pkg::ADDR_OPB:    s_nxt.opb = I_PWDATA[15:0];
			ixd_pkg::ADDR_OPC:    s_nxt.opc = I_PWDATA[15:0];
			ixd_pkg::ADDR_FLAGS:  s_nxt.flags = I_PWDATA[15:0] & 16'h010f;
			ixd_pkg::ADDR_IRQST:  s_nxt.irq_st = s_r.irq_st & ~I_PWDATA[1:0];
			ixd_pkg::ADDR_IRQMSK: s_nxt.irq_msk = I_PWDATA[1:0];
			default:              s_nxt.slverr = 1'b0;
			endcase
		end
		if (setup) begin
			s_nxt.slverr = I_PADDR > ixd_pkg::ADDR_BUSY || I_PADDR[1:0] != 2'h0;
		end
		if (acc_rd) begin
			case (I_PADDR)
			ixd_pkg::ADDR_CTRL:   s_nxt.prdata = {23'h0, s_r.ctrl};
			ixd_pkg::ADDR_OPA:    s_nxt.prdata = {16'h0, s_r.opa};
			ixd_pkg::ADDR_OPB:    s_nxt.prdata = {16'h0, s_r.opb};
			ixd_pkg::ADDR_OPC:    s_nxt.prdata = {16'h0, s_r.opc};
			ixd_pkg::ADDR_RES:    s_nxt.prdata = {16'h0, s_r.res};
			ixd_pkg::ADDR_RESHI:  s_nxt.prdata = {16'h0, s_r.reshi};
			ixd_pkg::ADDR_FLAGS:  s_nxt.prdata = {16'h0, s_r.flags};
			ixd_pkg::ADDR_QUOT:   s_nxt.prdata = {16'h0, s_r.quot};
			ixd_pkg::ADDR_REM:    s_nxt.prdata = {16'h0, s_r.rem};
			ixd_pkg::ADDR_IRQST:  s_nxt.prdata = {30'h0, s_r.irq_st};
			ixd_pkg::ADDR_IRQMSK: s_nxt.prdata = {30'h0, s_r.irq_msk};
			ixd_pkg::ADDR_BUSY:   s_nxt.prdata = {31'h0, s_r.busy};
			default:              s_nxt.prdata = 32'h00000000;
			endcase
		end

		// go bit self-clears; ignored while the divider runs
		if (s_r.ctrl[ixd_pkg::CTRL_GO]) begin
			s_nxt.ctrl[ixd_pkg::CTRL_GO] = 1'b0;
		end

		case (s_r.st)
		ST_IDLE: begin
			if (s_r.ctrl[ixd_pkg::CTRL_GO]) begin
				byt = s_r.ctrl[ixd_pkg::CTRL_BYTE];
				b_eff = s_r.opb;
				case (op)
				ixd_pkg::IXD_ADD, ixd_pkg::IXD_SUB: begin
					if (op == ixd_pkg::IXD_SUB) begin
						b_eff = ~s_r.opb;
					end
					// subtract adds the inverse plus one
					sum = {1'b0, src} + {1'b0, b_eff}
						+ {16'h0, op == ixd_pkg::IXD_SUB};
					nib = {1'b0, src[3:0]} + {1'b0, b_eff[3:0]}
						+ {4'h0, op == ixd_pkg::IXD_SUB};
					// borrow shows as carry clear
					dco = nib[4];
					r = sum[15:0];
					if (byt) begin
						r8 = src[7:0] + b_eff[7:0]
							+ {7'h0, op == ixd_pkg::IXD_SUB};
						co = ({1'b0, src[7:0]} + {1'b0, b_eff[7:0]}
							+ {8'h0, op == ixd_pkg::IXD_SUB}) > 9'h0ff;
						ovf = (src[7] == b_eff[7]) && (r8[7] != src[7]);
						r = {8'h00, r8};
					end else begin
						co = sum[16];
						ovf = (src[15] == b_eff[15]) && (r[15] != src[15]);
					end
					s_nxt.flags[ixd_pkg::FL_C] = co;
					s_nxt.flags[ixd_pkg::FL_DC] = dco;
					s_nxt.flags[ixd_pkg::FL_OV] = ovf;
				end
				ixd_pkg::IXD_AND: r = src & s_r.opb;
				ixd_pkg::IXD_IOR: r = src | s_r.opb;
				ixd_pkg::IXD_XOR: r = src ^ s_r.opb;
				ixd_pkg::IXD_SHIFT_A, ixd_pkg::IXD_SHIFT_L: r = shift_out;
				ixd_pkg::IXD_MUL_SS, ixd_pkg::IXD_MUL_UU,
				ixd_pkg::IXD_MUL_US, ixd_pkg::IXD_MUL_SL5,
				ixd_pkg::IXD_MUL_UL5, ixd_pkg::IXD_MUL_BB: begin
					// extension picks the signedness
					ma = {op == ixd_pkg::IXD_MUL_SS
						|| op == ixd_pkg::IXD_MUL_SL5 ? src[15] : 1'b0, src};
					mb = {op == ixd_pkg::IXD_MUL_SS
						|| op == ixd_pkg::IXD_MUL_US
						? s_r.opb[15] : 1'b0, s_r.opb};
					if (op == ixd_pkg::IXD_MUL_SL5
						|| op == ixd_pkg::IXD_MUL_UL5) begin
						mb = {12'h000, s_r.opb[4:0]};
					end
					if (op == ixd_pkg::IXD_MUL_BB) begin
						ma = {9'h000, src[7:0]};
						mb = {9'h000, s_r.opb[7:0]};
					end
					prod = 34'($signed(ma)) * 34'($signed(mb));
					r = prod[15:0];
					s_nxt.reshi = prod[31:16];
				end
				default: begin
					// divide: aligned pair, upper half in opc
					long = op == ixd_pkg::IXD_DIV_S32
						|| op == ixd_pkg::IXD_DIV_U32;
					sgn = op == ixd_pkg::IXD_DIV_S32
						|| op == ixd_pkg::IXD_DIV_S16;
					dvd = long ? {s_r.opc, s_r.opa}
						: {{16{sgn & s_r.opa[15]}}, s_r.opa};
					dvs = s_r.opb;
					if (dvs == 16'h0000) begin
						s_nxt.trap = 1'b1;
						ev[ixd_pkg::IRQ_DIV0] = 1'b1;
					end else begin
						s_nxt.neg_q = sgn & (dvd[31] ^ dvs[15]);
						s_nxt.neg_r = sgn & dvd[31];
						s_nxt.dq = (sgn & dvd[31]) ? 32'(-dvd) : dvd;
						s_nxt.dsr = (sgn & dvs[15]) ? 16'(-dvs) : dvs;
						s_nxt.acc = 17'h00000;
						s_nxt.cnt = 5'h00;
						s_nxt.busy = 1'b1;
						s_nxt.st = ST_DIV;
					end
				end
				endcase
				if (op <= ixd_pkg::IXD_MUL_BB) begin
					msb = byt ? r[7] : r[15];
					if (byt) begin
						r = {8'h00, r[7:0]};
					end
					s_nxt.res = r;
					s_nxt.flags[ixd_pkg::FL_Z] = byt ? r[7:0] == 8'h00
						: r == 16'h0000;
					s_nxt.flags[ixd_pkg::FL_N] = msb;
					// result may also go out to data memory
					s_nxt.mem_we = s_r.ctrl[ixd_pkg::CTRL_DST_MEM];
					s_nxt.mem_wdata = r;
					ev[ixd_pkg::IRQ_DONE] = 1'b1;
				end
			end
		end
		ST_DIV: begin
			// 32-bit dividend, low bits folded in over the 16 steps after the load
			// restoring division on the 32-bit magnitude, 16 steps
			// handle the high half as the starting remainder
			trial = {s_r.acc[15:0], s_r.dq[31]} - {1'b0, s_r.dsr};
			if (s_r.cnt == 5'h00) begin
				s_nxt.acc = {1'b0, s_r.dq[31:16]};
				s_nxt.dq = {s_r.dq[15:0], 16'h0000};
				s_nxt.cnt = 5'h01;
			end else begin
				trial = {s_r.acc[15:0], s_r.dq[31]} - {1'b0, s_r.dsr};
				if (!trial[16] || s_r.acc[16]) begin
					s_nxt.acc = trial;
					s_nxt.dq = {s_r.dq[30:0], 1'b1};
				end else begin
					s_nxt.acc = {s_r.acc[15:0], s_r.dq[31]};
					s_nxt.dq = {s_r.dq[30:0], 1'b0};
				end
				s_nxt.cnt = 5'(s_r.cnt + 5'h01);
				if (s_r.cnt == ixd_pkg::DIV_STEPS) begin
					s_nxt.st = ST_FIX;
				end
			end
		end
		ST_FIX: begin
			// writes held back until after the last step
			s_nxt.quot = s_r.neg_q ? 16'(-s_r.dq[15:0])
				: s_r.dq[15:0];
			s_nxt.rem = s_r.neg_r ? 16'(-s_r.acc[15:0])
				: s_r.acc[15:0];
			s_nxt.busy = 1'b0;
			s_nxt.st = ST_IDLE;
			ev[ixd_pkg::IRQ_DONE] = 1'b1;
		end
		default: s_nxt.st = ST_IDLE;
		endcase

		// hardware set wins over a software clear
		s_nxt.irq_st = s_nxt.irq_st | ev;
		s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_msk);
		if (acc_wr && I_PADDR == ixd_pkg::ADDR_IRQST
			&& I_PWDATA[ixd_pkg::IRQ_DIV0] && !ev[ixd_pkg::IRQ_DIV0]) begin
			s_nxt.trap = 1'b0;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			s_r <= '0;
			s_r.st <= ST_IDLE;
			s_r.flags <= ixd_pkg::FLAGS_RST;
			s_r.irq_st <= ixd_pkg::IRQ_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign O_PRDATA    = s_r.prdata;
	assign O_PREADY    = s_r.pready;
	assign O_PSLVERR   = s_r.slverr;
	assign O_BUSY      = s_r.busy;
	assign O_IRQ       = s_r.irq;
	assign O_MATH_TRAP = s_r.trap;
	assign O_MEM_WE    = s_r.mem_we;
	assign O_MEM_WDATA = s_r.mem_wdata;
endmodule : ixd_top

// file: sim/ixd_assertions.sv
// port-level timing checks for the execution datapath
`timescale 1ns/1ps
module ixd_assertions (
	input wire logic        I_CLK,
	input wire logic        I_RST,
	input wire logic        I_PSEL,
	input wire logic        I_PENABLE,
	input wire logic        I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic        O_PREADY,
	input wire logic        O_PSLVERR,
	input wire logic        O_BUSY,
	input wire logic        O_MATH_TRAP,
	input wire logic        O_MEM_WE
);
	logic [5:0] busy_cnt_r;
	// counts busy cycles so the length check needs no long repetition
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST)
			busy_cnt_r <= 6'h00;
		else
			busy_cnt_r <= O_BUSY ? busy_cnt_r + 6'h01 : 6'h00;
	end
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	a_ready_setup: assert property (
		I_PSEL && !I_PENABLE |=> O_PREADY)
		else $error("no ready after setup");
	a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready longer than one cycle");
	a_err_refuse: assert property (I_PSEL && !I_PENABLE &&
		(I_PADDR > 12'h02c || I_PADDR[1:0] != 2'h0) |=> O_PSLVERR)
		else $error("bad address not refused");
	a_busy_length: assert property ($fell(O_BUSY) |->
		busy_cnt_r == 6'h12)
		else $error("divide busy not 18 cycles");
	a_busy_bound: assert property (O_BUSY |-> ##[1:18] !O_BUSY)
		else $error("busy does not end");
	a_wr_withheld: assert property (O_BUSY |-> !O_MEM_WE)
		else $error("memory write while busy");
	a_we_pulse: assert property (O_MEM_WE |=> !O_MEM_WE)
		else $error("memory write longer than a cycle");
	a_trap_nobusy: assert property (
		$rose(O_MATH_TRAP) |-> !O_BUSY)
		else $error("zero divisor started divide");
	a_trap_sticky: assert property (
		O_MATH_TRAP && !(I_PSEL && I_PENABLE && I_PWRITE &&
		I_PADDR == 12'h024 && I_PWDATA[1]) |=> O_MATH_TRAP)
		else $error("trap dropped without clear");
endmodule : ixd_assertions
bind ixd_top ixd_assertions u_ixd_assertions (.I_CLK, .I_RST, .I_PSEL,
	.I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PREADY, .O_PSLVERR,
	.O_BUSY, .O_MATH_TRAP, .O_MEM_WE);

// file: sim/ixd_mem_model.sv
// data memory word standing behind the datapath's memory port
`timescale 1ns/1ps
module ixd_mem_model #(
	parameter logic [15:0] INIT = 16'h1234
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_we,
	input  wire logic [15:0] i_wdata,
	output logic      [15:0] o_rdata
);
	// one word only: enough to chain a stored result into a later operand
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			o_rdata <= INIT;
		else if (i_we)
			o_rdata <= i_wdata;
	end
endmodule : ixd_mem_model

// file: sim/cpu_alu_mul_div_shift_tb.sv
// self-checking bench for the integer execution datapath
`timescale 1ns/1ps
module cpu_alu_mul_div_shift_tb;
	logic        clk, rst, psel, pen, pwr, e, tr, byt;
	logic        rdy, err, busy, irq, trap, mwe;
	logic [11:0] paddr;
	logic [15:0] mdat, mwd, a, b, c, mk;
	logic [31:0] pwdata, prdata, rd, ex;
	logic [31:0] v[6];
	int          seed, o, i, nb;
	int          bad_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	ixd_top u_ixd_top (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .I_MEM_DATA(mdat), .O_PRDATA(prdata),
		.O_PREADY(rdy), .O_PSLVERR(err), .O_BUSY(busy), .O_IRQ(irq),
		.O_MATH_TRAP(trap), .O_MEM_WE(mwe), .O_MEM_WDATA(mwd));
	ixd_mem_model u_ixd_mem_model (.i_clk(clk), .i_rst(rst), .i_we(mwe),
		.i_wdata(mwd), .o_rdata(mdat));
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	task automatic conclude;
		if (bad_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [11:0] ad,
		input logic [31:0] d);
		psel <= 1'h1;
		pen <= 1'h0;
		pwr <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		do @(posedge clk); while (rdy !== 1'h1);
		rd = prdata;
		e = err;
		psel <= 1'h0;
		pen <= 1'h0;
		@(posedge clk);
	endtask : bus
	// operands, go, wait for done, then read RES..IRQST in address order
	task automatic run(input logic [8:0] ctl);
		int k;
		bus(1'h1, ixd_pkg::ADDR_OPA, {16'h0000, a});
		bus(1'h1, ixd_pkg::ADDR_OPB, {16'h0000, b});
		bus(1'h1, ixd_pkg::ADDR_OPC, {16'h0000, c});
		bus(1'h1, ixd_pkg::ADDR_CTRL, {23'h000000, ctl});
		nb = 0;
		// busy cycles counted while waiting for the done interrupt
		for (k = 0; k < 40 && irq !== 1'h1; k++) begin
			nb += (busy === 1'h1);
			@(posedge clk);
		end
		chk({31'h0, irq}, 32'h1);
		tr = trap;
		for (k = 0; k < 6; k++) begin
			bus(1'h0, ixd_pkg::ADDR_RES + 12'(4 * k), 32'h0);
			v[k] = rd;
		end
		bus(1'h1, ixd_pkg::ADDR_IRQST, 32'h3);
	endtask : run
	function automatic logic [31:0] alu(int op, logic [15:0] x, y,
		logic bt);
		logic [16:0] s;
		logic [4:0]  n;
		logic [15:0] r;
		logic        sb;
		int          m;
		sb = (op == 1);
		m = bt ? 7 : 15;
		y = sb ? ~y : y;
		if (bt)
			x[15:8] = 8'h00;
		if (bt)
			y[15:8] = 8'h00;
		s = x + y + sb;
		n = x[3:0] + y[3:0] + sb;
		r = op == 2 ? x & y : op == 3 ? x | y : op == 4 ? x ^ y : s[15:0];
		if (bt)
			r[15:8] = 8'h00;
		return {7'h00, n[4], 4'h0, r[m], x[m] == y[m] && r[m] != x[m],
			r == 16'h0000, s[m + 1], r};
	endfunction : alu
	function automatic logic [15:0] sh(logic [15:0] x, logic [4:0] k,
		logic ar);
		int n;
		n = $signed(k);
		if (n < 0)
			return x << -n;
		if (ar)
			return $signed(x) >>> n;
		return x >> n;
	endfunction : sh
	function automatic logic [31:0] mul(int op, logic [15:0] x, y);
		logic signed [16:0] p, q;
		logic signed [33:0] r;
		p = {(op == 7 || op == 10) && x[15], x};
		q = {(op == 7 || op == 9) && y[15], y};
		if (op > 9)
			q = {12'h000, y[4:0]};
		if (op == 12)
			p = {9'h000, x[7:0]};
		if (op == 12)
			q = {9'h000, y[7:0]};
		r = p * q;
		return r[31:0];
	endfunction : mul
	function automatic logic [31:0] dv(int op, logic [15:0] x, y, z);
		logic signed [32:0] n, d, q, r;
		n = op == 14 ? {1'h0, z, x} : op == 13 ? {z[15], z, x} :
			op == 16 ? {17'h00000, x} : {{17{x[15]}}, x};
		d = op % 2 == 0 ? {17'h00000, y} : {{17{y[15]}}, y};
		q = n / d;
		r = n % d;
		return {q[15:0], r[15:0]};
	endfunction : dv
	initial begin
		seed = 32'hcfaa1a9a;
		rst = 1'h1;
		psel = 1'h0;
		pen = 1'h0;
		pwr = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		bus(1'h0, ixd_pkg::ADDR_FLAGS, 32'h0);
		chk(rd, {16'h0000, ixd_pkg::FLAGS_RST});
		bus(1'h0, 12'h030, 32'h0);
		chk({31'h0, e}, 32'h1);
		bus(1'h1, 12'h006, 32'h1);
		chk({31'h0, e}, 32'h1);
		bus(1'h1, ixd_pkg::ADDR_IRQMSK, 32'h3);
		for (i = 0; i < 170; i++) begin
			o = i % 17;
			a = $random(seed);
			b = $random(seed);
			c = $random(seed);
			byt = o < 5 && i > 33 ? $random(seed) : 1'h0;
			// edge operands first: overflow, full-width left shift, zero
			if (i < 17)
				{a, b} = 32'h7fff0001;
			else if (i < 34)
				{a, b} = 32'h80000010;
			else if (i < 51)
				b = 16'h0000;
			if (o > 12 && (b == 16'h0000 || b == 16'hffff))
				b = 16'h0003;
			if (o == 14)
				c = c % b;
			if (o == 13)
				c = {16{a[15]}};
			run({3'h4, byt, 5'(o)});
			ex = alu(o, a, b, byt);
			mk = byt ? 16'h00ff : 16'hffff;
			chk(nb, o > 12 ? 32'h12 : 32'h0);
			if (o < 5)
				chk(v[0] & {16'h0, mk}, {16'h0, ex[15:0]});
			if (o < 2)
				chk(v[2] & 32'h10f, {16'h0, ex[31:16]});
			if (o == 5 || o == 6)
				chk(v[0], {16'h0, sh(a, b[4:0], o == 5)});
			if (o > 6 && o < 13)
				chk({v[1][15:0], v[0][15:0]}, mul(o, a, b));
			if (o > 12)
				chk({v[3][15:0], v[4][15:0]},
					dv(o, a, b, c));
		end
		{a, b, c} = 48'h000001010000;
		run(9'h1c0);
		chk({16'h0000, mdat}, 32'h1335);
		b = 16'h001c;
		run(9'h146);
		chk(v[0], 32'h3350);
		b = 16'h0000;
		run(9'h110);
		chk({31'h0, tr}, 32'h1);
		chk(nb, 32'h0);
		chk(v[5] & 32'h2, 32'h2);
		@(posedge clk);
		chk({31'h0, trap}, 32'h0);
		bus(1'h1, ixd_pkg::ADDR_IRQMSK, 32'h0);
		bus(1'h1, ixd_pkg::ADDR_CTRL, 32'h100);
		repeat (4) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		bus(1'h1, ixd_pkg::ADDR_IRQMSK, 32'h1);
		@(posedge clk);
		chk({31'h0, irq}, 32'h1);
		bus(1'h1, ixd_pkg::ADDR_IRQST, 32'h1);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		conclude();
	end
endmodule : cpu_alu_mul_div_shift_tb
